/* File: include/drive_params_pkg.sv */
// package: addresses, codes, reset values and carriers of the parameter bank
`default_nettype none
package drive_params_pkg;

  // *********************************************************************
  // parameter addresses
  // *********************************************************************
  localparam logic [15:0] ADDR_REF_EVAL = 16'h061C;
  localparam logic [15:0] ADDR_LIMN_EVAL = 16'h061E;
  localparam logic [15:0] ADDR_LIMP_EVAL = 16'h0620;
  localparam logic [15:0] ADDR_HALT_CODE = 16'h062E;
  localparam logic [15:0] ADDR_OUT_FUNC = 16'h071A;
  localparam logic [15:0] ADDR_JOG_SLOW = 16'h2908;
  localparam logic [15:0] ADDR_JOG_FAST = 16'h290A;
  localparam logic [15:0] ADDR_JOG_STEP = 16'h290E;
  localparam logic [15:0] ADDR_JOG_WAIT = 16'h2910;

  // *********************************************************************
  // values after reset
  // *********************************************************************
  localparam logic [15:0] RST_REF_EVAL = 16'h0001;
  localparam logic [15:0] RST_LIM_EVAL = 16'h0001;
  localparam logic [15:0] RST_HALT_CODE = 16'h0001;
  localparam logic [15:0] RST_OUT_FUNC = 16'h0001;
  localparam logic [31:0] RST_JOG_SLOW = 32'h0000003C;
  localparam logic [31:0] RST_JOG_FAST = 32'h000000B4;
  localparam logic [31:0] RST_JOG_STEP = 32'h00000014;
  localparam logic [15:0] RST_JOG_WAIT = 16'h01F4;

  // *********************************************************************
  // codes and limits
  // *********************************************************************
  localparam logic [15:0] EVAL_IGNORED = 16'h0000;
  localparam logic [15:0] EVAL_NC = 16'h0001;
  localparam logic [15:0] EVAL_NO = 16'h0002;
  localparam logic [15:0] HALT_DECEL = 16'h0001;
  localparam logic [15:0] HALT_TORQUE = 16'h0003;
  localparam logic [15:0] FN_FREE = 16'h0001;
  localparam logic [15:0] FN_NO_FAULT = 16'h0002;
  localparam logic [15:0] FN_ACTIVE = 16'h0003;
  localparam logic [15:0] FN_POS_WIN = 16'h0005;
  localparam logic [15:0] FN_VEL_WIN = 16'h0006;
  localparam logic [15:0] FN_VEL_LOW = 16'h0007;
  localparam logic [15:0] FN_CUR_LOW = 16'h0008;
  localparam logic [15:0] FN_HALT_ACK = 16'h0009;
  localparam logic [15:0] FN_STANDSTILL = 16'h000D;
  localparam logic [15:0] FN_SEL_ERROR = 16'h000E;
  localparam logic [15:0] FN_SEL_WARN = 16'h0010;
  localparam logic [31:0] JOG_MIN = 32'h00000001;
  localparam logic [31:0] JOG_MAX = 32'h7FFFFFFF;
  localparam logic [15:0] WAIT_MIN = 16'h0001;
  localparam logic [15:0] WAIT_MAX = 16'h7FFF;

  // *********************************************************************
  // carriers
  // *********************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } par_req_type;

  typedef struct packed {
    logic ready_to_switch_on;
    logic switched_on;
    logic operation_enabled;
    logic pos_dev_in_window;
    logic vel_dev_in_window;
    logic vel_below_threshold;
    logic cur_below_threshold;
    logic halt_acknowledge;
    logic standstill;
    logic selected_error;
    logic selected_warning;
  } drive_status_type;

endpackage
`default_nettype wire

/* File: design/drive_io_jog_halt_params.sv */
// module: parameter bank for output function, switch inputs, jog and halt
//
// Behaviour
// RULE_01: code 1 free; 2 ready, switched on or enabled; 3 enabled only.
// RULE_02: codes 5..8: position/velocity window, low speed, low current.
// RULE_03: codes 9,13,14,16: halt ack, standstill, error, warning.
// RULE_04: output function writable with stage off; applied at power-on.
// RULE_05: limit evaluation 0 ignored, 1 NC, 2 NO; default 1.
// RULE_06: switch evaluations writable with stage off; used from next enable.
// RULE_07: reference 1 NC, 2 NO, default 1; only during reference move.
// RULE_08: jog step signed 32 bit, 1..2147483647, default 20, next move.
// RULE_09: jog wait in ms, 1..32767, default 500, applied at next move.
// RULE_10: fast/slow jog velocities 180/60, clamped to ramp maximum, immediate.
// RULE_11: halt code 1 deceleration ramp, 3 torque ramp, default 1.
// RULE_12: halt code write refused during decel ramp; else immediate.
// RULE_13: out-of-range or undefined values are refused; stored value stays; output function and switch evaluation writes check only wdata[15:0].
`default_nettype none
module drive_io_jog_halt_params
  import drive_params_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire par_req_type par_req_in,
  output logic [31:0] par_rdata_out,
  output logic par_ack_out,
  output logic par_err_out,
  input wire drive_status_type status_in,
  input wire logic power_stage_enabled_in,
  input wire logic decel_ramp_active_in,
  input wire logic reference_move_in,
  input wire logic motor_move_start_in,
  input wire logic free_output_level_in,
  input wire logic [31:0] ramp_v_max_in,
  input wire logic neg_limit_pin_in,
  input wire logic pos_limit_pin_in,
  input wire logic ref_switch_pin_in,
  output logic output_four_out,
  output logic neg_limit_active_out,
  output logic pos_limit_active_out,
  output logic ref_switch_active_out,
  output logic [15:0] halt_reaction_out,
  output logic [31:0] jog_step_distance_out,
  output logic [15:0] jog_step_wait_time_out,
  output logic [31:0] jog_fast_velocity_out,
  output logic [31:0] jog_slow_velocity_out
);

  // *********************************************************************
  // helper functions
  // *********************************************************************
  // switch evaluation: NC trips on open contact (low), NO on closed (high)
  function automatic logic eval_switch(input logic [15:0] code,
                                       input logic level);
    return ((code == EVAL_NC) && !level) || ((code == EVAL_NO) && level);
  endfunction

  // clamp a jog velocity to the present ramp maximum
  function automatic logic [31:0] clamp_vel(input logic [31:0] v,
                                            input logic [31:0] vmax);
    return (v > vmax) ? vmax : v;
  endfunction

  // *********************************************************************
  // pin synchronisers
  // *********************************************************************
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;

  // two flops before any switch evaluation
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
    end else begin
      pin_meta_ff <= {ref_switch_pin_in, pos_limit_pin_in, neg_limit_pin_in};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // *********************************************************************
  // stored parameters and active copies
  // *********************************************************************
  logic [15:0] out_func_ff, nxt_out_func;
  logic [15:0] out_func_act_ff, nxt_out_func_act;
  logic [15:0] limn_ff, nxt_limn;
  logic [15:0] limp_ff, nxt_limp;
  logic [15:0] ref_ff, nxt_ref;
  logic [15:0] limn_act_ff, nxt_limn_act;
  logic [15:0] limp_act_ff, nxt_limp_act;
  logic [15:0] ref_act_ff, nxt_ref_act;
  logic [15:0] halt_ff, nxt_halt;
  logic [31:0] step_ff, nxt_step;
  logic [15:0] wait_ff, nxt_wait;
  logic [31:0] fast_ff, nxt_fast;
  logic [31:0] slow_ff, nxt_slow;
  logic boot_ff, nxt_boot;
  logic stage_d_ff, nxt_stage_d;
  logic [31:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack;
  logic err_ff, nxt_err;
  logic fn_ok;
  logic [15:0] w16;
  logic [31:0] w32;

  assign w16 = par_req_in.wdata[15:0];
  assign w32 = par_req_in.wdata;

  // defined output function codes
  always_comb begin
    case (w16)
      FN_FREE, FN_NO_FAULT, FN_ACTIVE, FN_POS_WIN, FN_VEL_WIN,
      FN_VEL_LOW, FN_CUR_LOW, FN_HALT_ACK, FN_STANDSTILL,
      FN_SEL_ERROR, FN_SEL_WARN: fn_ok = 1'b1;
      default: fn_ok = 1'b0;
    endcase
  end

  // write check, refusals, read mux and activation of copies
  always_comb begin
    logic ok;
    logic hit;
    ok = 1'b0;
    hit = 1'b1;
    nxt_out_func = out_func_ff;
    nxt_limn = limn_ff;
    nxt_limp = limp_ff;
    nxt_ref = ref_ff;
    nxt_halt = halt_ff;
    nxt_step = step_ff;
    nxt_wait = wait_ff;
    nxt_fast = fast_ff;
    nxt_slow = slow_ff;
    nxt_rdata = rdata_ff;
    nxt_ack = 1'b0;
    nxt_err = 1'b0;
    nxt_boot = 1'b1;
    nxt_stage_d = power_stage_enabled_in;
    nxt_limn_act = limn_act_ff;
    nxt_limp_act = limp_act_ff;
    nxt_ref_act = ref_act_ff;
    if (par_req_in.wr) begin
      case (par_req_in.addr)
        ADDR_OUT_FUNC: begin
          ok = fn_ok && !power_stage_enabled_in; // RULE_04 RULE_13
          nxt_out_func = ok ? w16 : out_func_ff;
        end
        ADDR_LIMN_EVAL: begin
          ok = (w16 <= EVAL_NO) && !power_stage_enabled_in; // RULE_05 RULE_06
          nxt_limn = ok ? w16 : limn_ff;
        end
        ADDR_LIMP_EVAL: begin
          ok = (w16 <= EVAL_NO) && !power_stage_enabled_in; // RULE_05 RULE_06
          nxt_limp = ok ? w16 : limp_ff;
        end
        ADDR_REF_EVAL: begin
          ok = (w16 == EVAL_NC || w16 == EVAL_NO)
               && !power_stage_enabled_in; // RULE_07 RULE_06
          nxt_ref = ok ? w16 : ref_ff;
        end
        ADDR_HALT_CODE: begin
          ok = (w16 == HALT_DECEL || w16 == HALT_TORQUE)
               && (w32[31:16] == 16'h0000)
               && !decel_ramp_active_in; // RULE_11 RULE_12
          nxt_halt = ok ? w16 : halt_ff;
        end
        ADDR_JOG_STEP: begin
          ok = (w32 >= JOG_MIN) && (w32 <= JOG_MAX); // RULE_08 RULE_13
          nxt_step = ok ? w32 : step_ff;
        end
        ADDR_JOG_WAIT: begin
          ok = (w32[31:16] == 16'h0000) && (w16 >= WAIT_MIN)
               && (w16 <= WAIT_MAX); // RULE_09 RULE_13
          nxt_wait = ok ? w16 : wait_ff;
        end
        ADDR_JOG_FAST: begin
          ok = (w32 >= JOG_MIN) && (w32 <= JOG_MAX); // RULE_13
          nxt_fast = ok ? w32 : fast_ff;
        end
        ADDR_JOG_SLOW: begin
          ok = (w32 >= JOG_MIN) && (w32 <= JOG_MAX); // RULE_13
          nxt_slow = ok ? w32 : slow_ff;
        end
        default: hit = 1'b0;
      endcase
      nxt_ack = ok;
      nxt_err = !ok; // RULE_13
    end else if (par_req_in.rd) begin
      nxt_rdata = 32'h00000000;
      case (par_req_in.addr)
        ADDR_OUT_FUNC: nxt_rdata = {16'h0000, out_func_ff};
        ADDR_LIMN_EVAL: nxt_rdata = {16'h0000, limn_ff};
        ADDR_LIMP_EVAL: nxt_rdata = {16'h0000, limp_ff};
        ADDR_REF_EVAL: nxt_rdata = {16'h0000, ref_ff};
        ADDR_HALT_CODE: nxt_rdata = {16'h0000, halt_ff};
        ADDR_JOG_STEP: nxt_rdata = step_ff;
        ADDR_JOG_WAIT: nxt_rdata = {16'h0000, wait_ff};
        ADDR_JOG_FAST: nxt_rdata = fast_ff;
        ADDR_JOG_SLOW: nxt_rdata = slow_ff;
        default: hit = 1'b0;
      endcase
      nxt_ack = hit;
      nxt_err = !hit;
    end
    // output function is fixed once, in the first cycle after power-on
    nxt_out_func_act = boot_ff ? out_func_act_ff : out_func_ff; // RULE_04
    // switch evaluations switch over on the power stage enable edge
    if (power_stage_enabled_in && !stage_d_ff) begin
      nxt_limn_act = limn_ff; // RULE_06
      nxt_limp_act = limp_ff; // RULE_06
      nxt_ref_act = ref_ff; // RULE_06
    end
  end

  // parameter storage
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_func_ff <= RST_OUT_FUNC;
      out_func_act_ff <= RST_OUT_FUNC;
      limn_ff <= RST_LIM_EVAL;
      limp_ff <= RST_LIM_EVAL;
      ref_ff <= RST_REF_EVAL;
      limn_act_ff <= RST_LIM_EVAL;
      limp_act_ff <= RST_LIM_EVAL;
      ref_act_ff <= RST_REF_EVAL;
      halt_ff <= RST_HALT_CODE;
      step_ff <= RST_JOG_STEP;
      wait_ff <= RST_JOG_WAIT;
      fast_ff <= RST_JOG_FAST;
      slow_ff <= RST_JOG_SLOW;
      boot_ff <= 1'b0;
      stage_d_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      out_func_ff <= nxt_out_func;
      out_func_act_ff <= nxt_out_func_act;
      limn_ff <= nxt_limn;
      limp_ff <= nxt_limp;
      ref_ff <= nxt_ref;
      limn_act_ff <= nxt_limn_act;
      limp_act_ff <= nxt_limp_act;
      ref_act_ff <= nxt_ref_act;
      halt_ff <= nxt_halt;
      step_ff <= nxt_step;
      wait_ff <= nxt_wait;
      fast_ff <= nxt_fast;
      slow_ff <= nxt_slow;
      boot_ff <= nxt_boot;
      stage_d_ff <= nxt_stage_d;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
    end
  end

  assign par_rdata_out = rdata_ff;
  assign par_ack_out = ack_ff;
  assign par_err_out = err_ff;

  // *********************************************************************
  // registered outputs
  // *********************************************************************
  logic dq_ff, nxt_dq;
  logic limn_hit_ff, nxt_limn_hit;
  logic limp_hit_ff, nxt_limp_hit;
  logic ref_hit_ff, nxt_ref_hit;
  logic [31:0] step_out_ff, nxt_step_out;
  logic [15:0] wait_out_ff, nxt_wait_out;
  logic [31:0] fast_out_ff, nxt_fast_out;
  logic [31:0] slow_out_ff, nxt_slow_out;

  // digital output by selected function, switch states, jog values
  always_comb begin
    case (out_func_act_ff)
      FN_FREE: nxt_dq = free_output_level_in; // RULE_01
      FN_NO_FAULT: nxt_dq = status_in.ready_to_switch_on
                            | status_in.switched_on
                            | status_in.operation_enabled; // RULE_01
      FN_ACTIVE: nxt_dq = status_in.operation_enabled; // RULE_01
      FN_POS_WIN: nxt_dq = status_in.pos_dev_in_window; // RULE_02
      FN_VEL_WIN: nxt_dq = status_in.vel_dev_in_window; // RULE_02
      FN_VEL_LOW: nxt_dq = status_in.vel_below_threshold; // RULE_02
      FN_CUR_LOW: nxt_dq = status_in.cur_below_threshold; // RULE_02
      FN_HALT_ACK: nxt_dq = status_in.halt_acknowledge; // RULE_03
      FN_STANDSTILL: nxt_dq = status_in.standstill; // RULE_03
      FN_SEL_ERROR: nxt_dq = status_in.selected_error; // RULE_03
      FN_SEL_WARN: nxt_dq = status_in.selected_warning; // RULE_03
      default: nxt_dq = 1'b0;
    endcase
    nxt_limn_hit = eval_switch(limn_act_ff, pin_sync_ff[0]); // RULE_05
    nxt_limp_hit = eval_switch(limp_act_ff, pin_sync_ff[1]); // RULE_05
    nxt_ref_hit = reference_move_in
                  && eval_switch(ref_act_ff, pin_sync_ff[2]); // RULE_07
    nxt_step_out = motor_move_start_in ? step_ff : step_out_ff; // RULE_08
    nxt_wait_out = motor_move_start_in ? wait_ff : wait_out_ff; // RULE_09
    nxt_fast_out = clamp_vel(fast_ff, ramp_v_max_in); // RULE_10
    nxt_slow_out = clamp_vel(slow_ff, ramp_v_max_in); // RULE_10
  end

  // output registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dq_ff <= 1'b0;
      limn_hit_ff <= 1'b0;
      limp_hit_ff <= 1'b0;
      ref_hit_ff <= 1'b0;
      step_out_ff <= RST_JOG_STEP;
      wait_out_ff <= RST_JOG_WAIT;
      fast_out_ff <= 32'h00000000;
      slow_out_ff <= 32'h00000000;
    end else begin
      dq_ff <= nxt_dq;
      limn_hit_ff <= nxt_limn_hit;
      limp_hit_ff <= nxt_limp_hit;
      ref_hit_ff <= nxt_ref_hit;
      step_out_ff <= nxt_step_out;
      wait_out_ff <= nxt_wait_out;
      fast_out_ff <= nxt_fast_out;
      slow_out_ff <= nxt_slow_out;
    end
  end

  assign output_four_out = dq_ff;
  assign neg_limit_active_out = limn_hit_ff;
  assign pos_limit_active_out = limp_hit_ff;
  assign ref_switch_active_out = ref_hit_ff;
  assign halt_reaction_out = halt_ff; // RULE_12
  assign jog_step_distance_out = step_out_ff;
  assign jog_step_wait_time_out = wait_out_ff;
  assign jog_fast_velocity_out = fast_out_ff;
  assign jog_slow_velocity_out = slow_out_ff;

endmodule
`default_nettype wire

/* File: sim/switch_contacts.sv */
// partner: limit and reference switch contacts wired to the drive pins
`default_nettype none
module switch_contacts (
  input wire logic neg_closed_in,
  input wire logic pos_closed_in,
  input wire logic ref_closed_in,
  output logic neg_limit_pin_out,
  output logic pos_limit_pin_out,
  output logic ref_switch_pin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // a closed contact pulls its pin high, an open one lets it fall low
  assign neg_limit_pin_out = neg_closed_in;
  assign pos_limit_pin_out = pos_closed_in;
  assign ref_switch_pin_out = ref_closed_in;
endmodule
`default_nettype wire

/* File: sim/drive_params_chk.sv */
// checker: port level properties of the parameter bank
`default_nettype none
module drive_params_chk
  import drive_params_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire par_req_type par_req_in,
  input wire logic par_ack_out,
  input wire logic par_err_out,
  input wire logic power_stage_enabled_in,
  input wire logic decel_ramp_active_in,
  input wire logic reference_move_in,
  input wire logic motor_move_start_in,
  input wire logic free_output_level_in,
  input wire logic [31:0] ramp_v_max_in,
  input wire logic output_four_out,
  input wire logic ref_switch_active_out,
  input wire logic [15:0] halt_reaction_out,
  input wire logic [31:0] jog_step_distance_out,
  input wire logic [31:0] jog_fast_velocity_out,
  input wire logic [31:0] jog_slow_velocity_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic req;
  logic hw;
  logic [31:0] d;
  // *****************
  // request decoding
  // *****************
  assign req = par_req_in.wr || par_req_in.rd;
  assign hw = par_req_in.wr && par_req_in.addr == ADDR_HALT_CODE;
  assign d = par_req_in.wdata;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // *****************
  // properties
  // *****************
  a_answer_once: assert property (req |=>
    par_ack_out != par_err_out)
    else $error("request not answered by exactly one pulse");
  a_idle_quiet: assert property (!req |=>
    !par_ack_out && !par_err_out)
    else $error("answer pulse without request");
  a_outfunc_locked: assert property (par_req_in.wr &&
    par_req_in.addr == ADDR_OUT_FUNC && power_stage_enabled_in |=> par_err_out)
    else $error("output function written with stage on");
  a_halt_blocked: assert property (hw && decel_ramp_active_in |=>
    par_err_out && $stable(halt_reaction_out))
    else $error("halt code changed during ramp");
  a_halt_range: assert property (hw && d != 32'h1 && d != 32'h3 |=>
    par_err_out && $stable(halt_reaction_out))
    else $error("undefined halt code taken");
  a_step_hold: assert property (!motor_move_start_in |=>
    $stable(jog_step_distance_out))
    else $error("jog step changed without move start");
  a_vel_clamp: assert property (1'b1 |=>
    jog_fast_velocity_out <= $past(ramp_v_max_in) &&
    jog_slow_velocity_out <= $past(ramp_v_max_in))
    else $error("jog velocity above ramp maximum");
  a_ref_gated: assert property (!reference_move_in [*3] |->
    !ref_switch_active_out)
    else $error("reference switch active outside reference move");
  a_free_output: assert property (1'b1 |=>
    output_four_out == $past(free_output_level_in))
    else $error("free output does not follow its level");
endmodule
bind drive_io_jog_halt_params drive_params_chk i_chk (.sys_clk_in,
  .rst_n_in, .par_req_in, .par_ack_out, .par_err_out,
  .power_stage_enabled_in, .decel_ramp_active_in, .reference_move_in,
  .motor_move_start_in, .free_output_level_in, .ramp_v_max_in,
  .output_four_out, .ref_switch_active_out, .halt_reaction_out,
  .jog_step_distance_out, .jog_fast_velocity_out, .jog_slow_velocity_out);
`default_nettype wire

/* File: sim/drive_io_jog_halt_params_tb.sv */
// testbench: parameter bank with random and corner stimulus
`default_nettype none
module drive_io_jog_halt_params_tb;
  import drive_params_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [17:0] FMASK = 18'h163EE;
  logic sys_clk_in = 1'b0, rst_n_in = 1'b0;
  par_req_type par_req_in = '0;
  drive_status_type status_in = '0;
  logic power_stage_enabled_in = 1'b0, decel_ramp_active_in = 1'b0;
  logic reference_move_in = 1'b0, motor_move_start_in = 1'b0;
  logic free_output_level_in = 1'b0;
  logic [31:0] ramp_v_max_in = 32'h0000FFFF;
  logic cl_neg = 1'b0, cl_pos = 1'b0, cl_ref = 1'b0;
  logic neg_limit_pin_in, pos_limit_pin_in, ref_switch_pin_in;
  logic [31:0] par_rdata_out, jog_step_distance_out;
  logic [31:0] jog_fast_velocity_out, jog_slow_velocity_out;
  logic [15:0] halt_reaction_out, jog_step_wait_time_out;
  logic par_ack_out, par_err_out, output_four_out;
  logic neg_limit_active_out, pos_limit_active_out, ref_switch_active_out;
  logic [31:0] seed = 32'h907B4703;
  logic [31:0] v, s;
  int mismatches = 0, samples_checked = 0;
  logic [15:0] ra [9] = '{ADDR_REF_EVAL, ADDR_LIMN_EVAL, ADDR_LIMP_EVAL,
    ADDR_HALT_CODE, ADDR_OUT_FUNC, ADDR_JOG_SLOW, ADDR_JOG_FAST,
    ADDR_JOG_STEP, ADDR_JOG_WAIT};
  logic [31:0] rv [9] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h3C,
    32'hB4, 32'h14, 32'h1F4};

  drive_io_jog_halt_params i_dut (.sys_clk_in, .rst_n_in, .par_req_in,
    .par_rdata_out, .par_ack_out, .par_err_out, .status_in,
    .power_stage_enabled_in, .decel_ramp_active_in, .reference_move_in,
    .motor_move_start_in, .free_output_level_in, .ramp_v_max_in,
    .neg_limit_pin_in, .pos_limit_pin_in, .ref_switch_pin_in,
    .output_four_out, .neg_limit_active_out, .pos_limit_active_out,
    .ref_switch_active_out, .halt_reaction_out, .jog_step_distance_out,
    .jog_step_wait_time_out, .jog_fast_velocity_out,
    .jog_slow_velocity_out);
  switch_contacts i_sw (.neg_closed_in(cl_neg), .pos_closed_in(cl_pos),
    .ref_closed_in(cl_ref), .neg_limit_pin_out(neg_limit_pin_in),
    .pos_limit_pin_out(pos_limit_pin_in),
    .ref_switch_pin_out(ref_switch_pin_in));

  // ******************
  // clock and helpers
  // ******************
  always #2 sys_clk_in = ~sys_clk_in;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one access, answer checked, then one idle cycle
  task automatic acc(input logic w, input logic [15:0] a,
    input logic [31:0] d, input logic e, input logic [31:0] r);
    par_req_in = '{addr: a, wdata: d, wr: w, rd: !w};
    cyc(1);
    chk(par_err_out, e);
    chk(par_ack_out, !e);
    if (!w) chk(par_rdata_out, r);
    par_req_in = '0;
    cyc(1);
  endtask

  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    mismatches++;
    report_and_stop;
  end

  // *****************
  // main sequence
  // *****************
  initial begin
    cyc(12);
    rst_n_in = 1'b1;
    cyc(2);
    foreach (ra[i]) acc(0, ra[i], 0, 0, rv[i]);
    chk(jog_fast_velocity_out, 32'hB4);
    chk(jog_step_distance_out, 32'h14);
    acc(0, 16'h0622, 0, 1, 0);
    acc(1, 16'h0000, 1, 1, 0);
    power_stage_enabled_in = 1'b1;
    for (int i = 0; i < 5; i++) if (i != 3) acc(1, ra[i], 2, 1, 0);
    power_stage_enabled_in = 1'b0;
    acc(0, ADDR_LIMN_EVAL, 0, 0, 1);
    decel_ramp_active_in = 1'b1;
    acc(1, ADDR_HALT_CODE, 3, 1, 0);
    decel_ramp_active_in = 1'b0;
    for (int c = 0; c < 5; c++) begin
      acc(1, ADDR_HALT_CODE, c, c[0] != 1, 0);
    end
    acc(1, ADDR_HALT_CODE, 32'h00010001, 1, 0);
    chk(halt_reaction_out, HALT_TORQUE);
    for (int c = 0; c < 4; c++) begin
      acc(1, ADDR_LIMP_EVAL, c, c == 3, 0);
      acc(1, ADDR_REF_EVAL, c, c == 0 || c == 3, 0);
    end
    for (int c = 0; c < 18; c++) begin
      acc(1, ADDR_OUT_FUNC, c, !FMASK[c], 0);
    end
    acc(1, ADDR_JOG_WAIT, 32'h7FFF, 0, 0);
    acc(1, ADDR_JOG_WAIT, 32'h8000, 1, 0);
    acc(1, ADDR_JOG_WAIT, 0, 1, 0);
    acc(1, ADDR_JOG_STEP, 0, 1, 0);
    acc(1, ADDR_JOG_STEP, 32'h80000000, 1, 0);
    for (int n = 0; n < 24; n++) begin
      seed = lfsr(seed);
      v = {1'b0, seed[30:0]} | 32'h1;
      s = lfsr(seed);
      status_in = s[10:0];
      free_output_level_in = s[11];
      ramp_v_max_in = {1'b0, s[31:1]};
      cyc(1);
      chk(output_four_out, free_output_level_in);
      acc(1, n[0] ? ADDR_JOG_FAST : ADDR_JOG_SLOW, v, 0, 0);
      chk(n[0] ? jog_fast_velocity_out : jog_slow_velocity_out,
        v < ramp_v_max_in ? v : ramp_v_max_in);
      s = jog_step_distance_out;
      acc(1, ADDR_JOG_STEP, v, 0, 0);
      chk(jog_step_distance_out, s);
      chk(jog_step_wait_time_out, n == 0 ? 16'h01F4 : 16'h7FFF);
      motor_move_start_in = 1'b1;
      cyc(1);
      motor_move_start_in = 1'b0;
      chk(jog_step_distance_out, v);
      chk(jog_step_wait_time_out, 16'h7FFF);
    end
    acc(1, ADDR_LIMN_EVAL, 2, 0, 0);
    acc(1, ADDR_LIMP_EVAL, 0, 0, 0);
    acc(1, ADDR_REF_EVAL, 1, 0, 0);
    cyc(5);
    chk(neg_limit_active_out, 1);
    chk(pos_limit_active_out, 1);
    power_stage_enabled_in = 1'b1;
    cyc(5);
    chk(neg_limit_active_out, 0);
    chk(pos_limit_active_out, 0);
    chk(ref_switch_active_out, 0);
    cl_neg = 1'b1;
    cl_pos = 1'b1;
    reference_move_in = 1'b1;
    cyc(5);
    chk(neg_limit_active_out, 1);
    chk(pos_limit_active_out, 0);
    chk(ref_switch_active_out, 1);
    reference_move_in = 1'b0;
    cyc(5);
    chk(ref_switch_active_out, 0);
    rst_n_in = 1'b0;
    cyc(2);
    chk(halt_reaction_out, 16'h1);
    rst_n_in = 1'b1;
    cyc(2);
    acc(0, ADDR_OUT_FUNC, 0, 0, 1);
    report_and_stop;
  end
endmodule
`default_nettype wire
